// ### design/bsir_cfg.svh
// Purpose: constants of the burner status and identification register bank
// Assumes: 100 MHz clock, AXI4-Lite register access
// Notes:   byte address of a register is four times its index
//
// Summary of operation
// - every register 16 bits, unused bits zero
// - reg 22 low: state, or error code
// - reg 22 high: flame quality, 0.1 uA
// - fault: reg 22 high holds error info
// - runtime seconds in regs 23-24, LSB first
// - start counter in regs 25-26, LSB first
// - valve two cycles in regs 27-28
// - valve two runtime in regs 29-30
// - reg 31: error info low, high zero
// - firmware article regs 32-33 plus index
// - production day, month, year regs 34-35
// - serial number in regs 36-37
// - hardware article regs 38-39 plus index
// - unit article regs 40-41 plus index
`ifndef BSIR_CFG_SVH
`define BSIR_CFG_SVH
// ------------------------------------------------------------
// register indices
// ------------------------------------------------------------
`define BSIR_IDX_STATE      6'h16
`define BSIR_IDX_RUN_LO     6'h17
`define BSIR_IDX_RUN_HI     6'h18
`define BSIR_IDX_START_LO   6'h19
`define BSIR_IDX_START_HI   6'h1a
`define BSIR_IDX_VCYC_LO    6'h1b
`define BSIR_IDX_VCYC_HI    6'h1c
`define BSIR_IDX_VRUN_LO    6'h1d
`define BSIR_IDX_VRUN_HI    6'h1e
`define BSIR_IDX_ERRINFO    6'h1f
`define BSIR_IDX_FW_LO      6'h20
`define BSIR_IDX_FW_HI      6'h21
`define BSIR_IDX_DATE_LO    6'h22
`define BSIR_IDX_DATE_HI    6'h23
`define BSIR_IDX_SER_LO     6'h24
`define BSIR_IDX_SER_HI     6'h25
`define BSIR_IDX_HW_LO      6'h26
`define BSIR_IDX_HW_HI      6'h27
`define BSIR_IDX_UNIT_LO    6'h28
`define BSIR_IDX_UNIT_HI    6'h29
`define BSIR_IDX_IRQ_STAT   6'h2c
`define BSIR_IDX_IRQ_MASK   6'h2d
`define BSIR_IDX_CONTROL    6'h2e
// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define BSIR_EV_FAULT_SET   0
`define BSIR_EV_FAULT_CLR   1
`define BSIR_EV_START       2
`define BSIR_EV_WIDTH       3
`define BSIR_CTL_CLR_RUN    0
`define BSIR_CTL_CLR_START  1
`define BSIR_RST_MASK       3'h0
`define BSIR_RST_COUNT      32'h0000_0000
`define BSIR_RESP_OKAY      2'h0
`define BSIR_RESP_SLVERR    2'h2
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define BSIR_CLK_PERIOD_NS  10
`define BSIR_SECOND_NS      1000000000
`endif

// ### design/bsir_pkg.sv
// Purpose: shared types of the burner status register bank
// Assumes: constants live in bsir_cfg.svh
// Notes:   types only
package bsir_pkg;
   typedef logic [15:0] bsir_word_t;
   typedef logic [7:0]  bsir_byte_t;
   typedef logic [1:0]  bsir_resp_t;
   typedef logic [7:0]  bsir_addr_t;
   typedef logic [2:0]  bsir_events_t;
endpackage : bsir_pkg

// ### design/bsir_status_bank.sv
// Purpose: status and identification bank behind an AXI4-Lite slave, read-only but for the interrupt and control words
// Assumes: status inputs come from logic on the same clock
// Notes:   read data one cycle after the address is taken
`timescale 1ns/100ps
`include "bsir_cfg.svh"
module bsir_status_bank #(
   parameter int unsigned SECOND_CYCLES = `BSIR_SECOND_NS / `BSIR_CLK_PERIOD_NS,
   parameter logic [23:0] FW_ARTICLE    = 24'h000001,   // arbitrary value
   parameter logic [7:0]  FW_INDEX      = 8'h01,        // arbitrary value
   parameter logic [7:0]  PROD_DAY      = 8'h01,
   parameter logic [7:0]  PROD_MONTH    = 8'h01,
   parameter logic [7:0]  PROD_YEAR     = 8'h00,
   parameter logic [31:0] SERIAL        = 32'h00000001, // arbitrary value
   parameter logic [23:0] HW_ARTICLE    = 24'h000002,   // arbitrary value
   parameter logic [7:0]  HW_INDEX      = 8'h01,        // arbitrary value
   parameter logic [23:0] UNIT_ARTICLE  = 24'h000003,   // arbitrary value
   parameter logic [7:0]  UNIT_INDEX    = 8'h01         // arbitrary value
) (
   // clock and reset
   input  wire logic               clock,
   input  wire logic               rstn,
   // burner sequencer status
   input  wire logic               fault,
   input  wire bsir_pkg::bsir_byte_t stateNumber,
   input  wire bsir_pkg::bsir_byte_t errorCode,
   input  wire bsir_pkg::bsir_byte_t flameQuality,
   input  wire bsir_pkg::bsir_byte_t extraErrorInfo,
   input  wire logic               burnerOn,
   input  wire logic               startPulse,
   input  wire logic               secondGasValveOpen,
   // axi4-lite write channels
   input  wire bsir_pkg::bsir_addr_t awaddr,
   input  wire logic               awvalid,
   output logic                    awready,
   input  wire logic [31:0]        wdata,
   input  wire logic [3:0]         wstrb,
   input  wire logic               wvalid,
   output logic                    wready,
   output bsir_pkg::bsir_resp_t    bresp,
   output logic                    bvalid,
   input  wire logic               bready,
   // axi4-lite read channels
   input  wire bsir_pkg::bsir_addr_t araddr,
   input  wire logic               arvalid,
   output logic                    arready,
   output logic [31:0]             rdata,
   output bsir_pkg::bsir_resp_t    rresp,
   output logic                    rvalid,
   input  wire logic               rready,
   // interrupt
   output logic                    irq
);
   import bsir_pkg::*;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // word index of a byte address
   function automatic logic [5:0] regIndex(input bsir_addr_t addr);
      regIndex = addr[7:2];
   endfunction : regIndex

   logic [31:0]  runtimeMeter;
   logic [31:0]  startCount;
   logic [31:0]  valveCycles;
   logic [31:0]  valveRuntime;
   logic [15:0]  runShadow;
   logic [15:0]  startShadow;
   logic [15:0]  cycShadow;
   logic [15:0]  vlvRunShadow;
   logic [31:0]  secondCount;
   logic         secondTick;
   logic         valveOpenQ;
   logic         faultQ;
   bsir_events_t irqStatus;
   bsir_events_t irqMask;
   bsir_events_t events;
   logic         awHeld;
   logic         wHeld;
   bsir_addr_t   awAddrQ;
   logic [31:0]  wDataQ;
   logic [3:0]   wStrbQ;
   logic         doWrite;
   logic         arTaken;
   logic [5:0]   rdIdx;
   logic [5:0]   wrIdx;
   bsir_word_t   rdWord;
   logic         rdHit;
   logic         wrHit;
   logic         clearRun;
   logic         clearStart;

   // ------------------------------------------------------------
   // second divider
   // ------------------------------------------------------------
   // one-cycle pulse per second; meters count in whole seconds
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         secondCount <= 32'h0;
         secondTick  <= 1'b0;
      end else if (secondCount == SECOND_CYCLES - 1) begin
         secondCount <= 32'h0;
         secondTick  <= 1'b1;
      end else begin
         secondCount <= secondCount + 32'h1;
         secondTick  <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // counters
   // ------------------------------------------------------------
   assign clearRun   = doWrite && wrIdx == `BSIR_IDX_CONTROL && wStrbQ[0] && wDataQ[`BSIR_CTL_CLR_RUN];
   assign clearStart = doWrite && wrIdx == `BSIR_IDX_CONTROL && wStrbQ[0] && wDataQ[`BSIR_CTL_CLR_START];

   // resettable runtime meter
   // software clear wins over a tick in the same cycle
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) runtimeMeter <= `BSIR_RST_COUNT;
      else if (clearRun) runtimeMeter <= `BSIR_RST_COUNT;
      else if (secondTick && burnerOn) runtimeMeter <= runtimeMeter + 32'h1;
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) startCount <= `BSIR_RST_COUNT;
      else if (clearStart) startCount <= `BSIR_RST_COUNT;
      else if (startPulse) startCount <= startCount + 32'h1;
   end

   // valve two switching cycles, counted on opening
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         valveOpenQ  <= 1'b0;
         valveCycles <= `BSIR_RST_COUNT;
      end else begin
         valveOpenQ <= secondGasValveOpen;
         if (secondGasValveOpen && !valveOpenQ) valveCycles <= valveCycles + 32'h1;
      end
   end

   // valve two runtime in seconds while open
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) valveRuntime <= `BSIR_RST_COUNT;
      else if (secondTick && secondGasValveOpen) valveRuntime <= valveRuntime + 32'h1;
   end

   // ------------------------------------------------------------
   // interrupts
   // ------------------------------------------------------------
   assign events[`BSIR_EV_FAULT_SET] = fault && !faultQ;
   assign events[`BSIR_EV_FAULT_CLR] = !fault && faultQ;
   assign events[`BSIR_EV_START]     = startPulse;

   // sticky status, write one to clear; a new event beats the clear
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         faultQ    <= 1'b0;
         irqStatus <= '0;
      end else begin
         faultQ <= fault;
         if (doWrite && wrIdx == `BSIR_IDX_IRQ_STAT && wStrbQ[0])
            irqStatus <= (irqStatus & ~wDataQ[`BSIR_EV_WIDTH-1:0]) | events;
         else
            irqStatus <= irqStatus | events;
      end
   end

   // mask register, a one enables the bit
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) irqMask <= `BSIR_RST_MASK;
      else if (doWrite && wrIdx == `BSIR_IDX_IRQ_MASK && wStrbQ[0]) irqMask <= wDataQ[`BSIR_EV_WIDTH-1:0];
   end

   // registered so the pin is glitch free
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) irq <= 1'b0;
      else irq <= |(irqStatus & irqMask);
   end

   // ------------------------------------------------------------
   // write channels
   // ------------------------------------------------------------
   assign wrIdx   = regIndex(awAddrQ);
   assign doWrite = awHeld && wHeld && !bvalid;
   assign wrHit   = (wrIdx >= `BSIR_IDX_STATE && wrIdx <= `BSIR_IDX_UNIT_HI)
                 || (wrIdx >= `BSIR_IDX_IRQ_STAT && wrIdx <= `BSIR_IDX_CONTROL);

   // address and data are taken in either order and held until the write
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         awready <= 1'b0;
         awHeld  <= 1'b0;
         awAddrQ <= '0;
      end else if (awvalid && awready) begin
         awready <= 1'b0;
         awHeld  <= 1'b1;
         awAddrQ <= awaddr;
      end else begin
         if (doWrite) awHeld <= 1'b0;
         if (!awHeld && !bvalid) awready <= 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wready <= 1'b0;
         wHeld  <= 1'b0;
         wDataQ <= '0;
         wStrbQ <= '0;
      end else if (wvalid && wready) begin
         wready <= 1'b0;
         wHeld  <= 1'b1;
         wDataQ <= wdata;
         wStrbQ <= wstrb;
      end else begin
         if (doWrite) wHeld <= 1'b0;
         if (!wHeld && !bvalid) wready <= 1'b1;
      end
   end

   // read-only words ignore writes; unmapped addresses answer slverr
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         bvalid <= 1'b0;
         bresp  <= `BSIR_RESP_OKAY;
      end else if (doWrite) begin
         bvalid <= 1'b1;
         bresp  <= wrHit ? `BSIR_RESP_OKAY : `BSIR_RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // read decode
   // ------------------------------------------------------------
   assign rdIdx   = regIndex(araddr);
   assign arTaken = arvalid && arready;

   // each word 16 bits; unused bytes forced to zero
   always_comb begin
      rdWord = 16'h0;
      rdHit  = 1'b1;
      unique case (rdIdx)
         // state or error, quality or error info
         `BSIR_IDX_STATE:    rdWord = fault ? {extraErrorInfo, errorCode} : {flameQuality, stateNumber};
         `BSIR_IDX_RUN_LO:   rdWord = runtimeMeter[15:0];
         `BSIR_IDX_RUN_HI:   rdWord = runShadow;
         `BSIR_IDX_START_LO: rdWord = startCount[15:0];
         `BSIR_IDX_START_HI: rdWord = startShadow;
         `BSIR_IDX_VCYC_LO:  rdWord = valveCycles[15:0];
         `BSIR_IDX_VCYC_HI:  rdWord = cycShadow;
         `BSIR_IDX_VRUN_LO:  rdWord = valveRuntime[15:0];
         `BSIR_IDX_VRUN_HI:  rdWord = vlvRunShadow;
         // first error info, high byte zero
         `BSIR_IDX_ERRINFO:  rdWord = {8'h00, extraErrorInfo};
         // firmware article, lsb first, then index
         `BSIR_IDX_FW_LO:    rdWord = FW_ARTICLE[15:0];
         `BSIR_IDX_FW_HI:    rdWord = {FW_INDEX, FW_ARTICLE[23:16]};
         `BSIR_IDX_DATE_LO:  rdWord = {PROD_MONTH, PROD_DAY};
         `BSIR_IDX_DATE_HI:  rdWord = {8'h00, PROD_YEAR};
         `BSIR_IDX_SER_LO:   rdWord = SERIAL[15:0];
         `BSIR_IDX_SER_HI:   rdWord = SERIAL[31:16];
         `BSIR_IDX_HW_LO:    rdWord = HW_ARTICLE[15:0];
         `BSIR_IDX_HW_HI:    rdWord = {HW_INDEX, HW_ARTICLE[23:16]};
         `BSIR_IDX_UNIT_LO:  rdWord = UNIT_ARTICLE[15:0];
         `BSIR_IDX_UNIT_HI:  rdWord = {UNIT_INDEX, UNIT_ARTICLE[23:16]};
         `BSIR_IDX_IRQ_STAT: rdWord = {13'h0, irqStatus};
         `BSIR_IDX_IRQ_MASK: rdWord = {13'h0, irqMask};
         `BSIR_IDX_CONTROL:  rdWord = 16'h0;
         default:            rdHit  = 1'b0;
      endcase
   end

   // reading a low half freezes its high half
   // counters may carry between two reads; the shadow keeps the pair whole
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         runShadow   <= 16'h0;
         startShadow <= 16'h0;
         cycShadow   <= 16'h0;
         vlvRunShadow <= 16'h0;
      end else if (arTaken) begin
         if (rdIdx == `BSIR_IDX_RUN_LO)   runShadow   <= runtimeMeter[31:16];
         if (rdIdx == `BSIR_IDX_START_LO) startShadow <= startCount[31:16];
         if (rdIdx == `BSIR_IDX_VCYC_LO)  cycShadow    <= valveCycles[31:16];
         if (rdIdx == `BSIR_IDX_VRUN_LO)  vlvRunShadow <= valveRuntime[31:16];
      end
   end

   // ------------------------------------------------------------
   // read channels
   // ------------------------------------------------------------
   // data one cycle after the address handshake, held until rready
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0;
         rresp   <= `BSIR_RESP_OKAY;
      end else if (arTaken) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= {16'h0, rdWord};
         rresp   <= rdHit ? `BSIR_RESP_OKAY : `BSIR_RESP_SLVERR;
      end else begin
         if (rvalid && rready) rvalid <= 1'b0;
         if (!rvalid) arready <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_readOf(logic [5:0] idx);
      arvalid && arready && araddr[7:2] == idx;
   endsequence

   a_upper_half_zero: assert property (@(posedge clock) disable iff (!rstn)
      rvalid |-> rdata[31:16] == 16'h0) else $error("upper half of read data not zero");
   a_state_low_byte: assert property (@(posedge clock) disable iff (!rstn)
      s_readOf(`BSIR_IDX_STATE) |=> rdata[7:0] == ($past(fault) ? $past(errorCode) : $past(stateNumber)))
      else $error("state or error byte wrong");
   a_flame_quality: assert property (@(posedge clock) disable iff (!rstn)
      s_readOf(`BSIR_IDX_STATE) ##0 !fault |=> rdata[15:8] == $past(flameQuality))
      else $error("flame quality byte wrong");
   a_fault_info_high: assert property (@(posedge clock) disable iff (!rstn)
      s_readOf(`BSIR_IDX_STATE) ##0 fault |=> rdata[15:8] == $past(extraErrorInfo))
      else $error("fault info byte wrong");
   a_runtime_low: assert property (@(posedge clock) disable iff (!rstn)
      s_readOf(`BSIR_IDX_RUN_LO) |=> rdata[15:0] == $past(runtimeMeter[15:0]))
      else $error("runtime low half wrong");
   a_start_counts: assert property (@(posedge clock) disable iff (!rstn)
      startPulse && !clearStart |=> startCount == $past(startCount) + 32'h1)
      else $error("start counter missed a start");
   a_valve_cycles: assert property (@(posedge clock) disable iff (!rstn)
      secondGasValveOpen && !valveOpenQ |=> valveCycles == $past(valveCycles) + 32'h1)
      else $error("valve cycle not counted");
   a_valve_runtime: assert property (@(posedge clock) disable iff (!rstn)
      !secondGasValveOpen |=> $stable(valveRuntime)) else $error("valve runtime moved while closed");
   a_error_info_reg: assert property (@(posedge clock) disable iff (!rstn)
      s_readOf(`BSIR_IDX_ERRINFO) |=> rdata[15:0] == {8'h00, $past(extraErrorInfo)})
      else $error("error info word wrong");
   a_fw_article_hi: assert property (@(posedge clock) disable iff (!rstn)
      s_readOf(`BSIR_IDX_FW_HI) |=> rdata[15:0] == {FW_INDEX, FW_ARTICLE[23:16]})
      else $error("firmware article high word wrong");
   a_date_year: assert property (@(posedge clock) disable iff (!rstn)
      s_readOf(`BSIR_IDX_DATE_HI) |=> rdata[15:0] == {8'h00, PROD_YEAR}) else $error("year word wrong");
   a_serial_high: assert property (@(posedge clock) disable iff (!rstn)
      s_readOf(`BSIR_IDX_SER_HI) |=> rdata[15:0] == SERIAL[31:16]) else $error("serial high word wrong");
   a_hw_article_hi: assert property (@(posedge clock) disable iff (!rstn)
      s_readOf(`BSIR_IDX_HW_HI) |=> rdata[15:0] == {HW_INDEX, HW_ARTICLE[23:16]})
      else $error("hardware article high word wrong");
   a_unit_article_hi: assert property (@(posedge clock) disable iff (!rstn)
      s_readOf(`BSIR_IDX_UNIT_HI) |=> rdata[15:0] == {UNIT_INDEX, UNIT_ARTICLE[23:16]})
      else $error("unit article high word wrong");
   a_pair_coherent: assert property (@(posedge clock) disable iff (!rstn)
      s_readOf(`BSIR_IDX_RUN_LO) |=> runShadow == $past(runtimeMeter[31:16]))
      else $error("runtime shadow not captured");
endmodule : bsir_status_bank

// ### tb/bsir_bus_master.sv
// Purpose: axi4-lite master standing in for the host that polls the bank
// Assumes: the bench calls one task at a time
// Notes:   waits are open here; the bench watchdog cuts a hang short
`timescale 1ns/100ps
module bsir_bus_master (
   // clock
   input  wire logic            clock,
   // write channels
   output bsir_pkg::bsir_addr_t awaddr,
   output logic                 awvalid,
   input  wire logic            awready,
   output logic [31:0]          wdata,
   output logic [3:0]           wstrb,
   output logic                 wvalid,
   input  wire logic            wready,
   input  wire logic            bvalid,
   output logic                 bready,
   // read channels
   output bsir_pkg::bsir_addr_t araddr,
   output logic                 arvalid,
   input  wire logic            arready,
   input  wire logic            rvalid,
   output logic                 rready
);
   import bsir_pkg::*;
   // idle bus from time zero
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata, wstrb} = 52'h0;
   end
   // both channels offered together, each released at its own handshake
   task automatic wr(input bsir_addr_t a, input logic [31:0] d);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'hf;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      do begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while ((awvalid && !awready) || (wvalid && !wready));
      bready <= 1'b1;
      do @(posedge clock); while (!bvalid);
      bready <= 1'b0;
   endtask : wr
   // address held until taken, then rready held until data comes
   task automatic rd(input bsir_addr_t a);
      araddr  <= a;
      arvalid <= 1'b1;
      do @(posedge clock); while (!arready);
      arvalid <= 1'b0;
      rready  <= 1'b1;
      do @(posedge clock); while (!rvalid);
      rready  <= 1'b0;
   endtask : rd
endmodule : bsir_bus_master

// ### tb/burner_status_ident_registers_bench.sv
// Purpose: self-checking bench of the status and identification bank
// Assumes: SECOND_CYCLES cut to 10 so a second is ten clocks
// Notes:   expected bus answers queue up; a monitor pops them in order
`timescale 1ns/100ps
`include "bsir_cfg.svh"
module burner_status_ident_registers_bench;
   import bsir_pkg::*;
   // ------------------------------------------------------------
   // identification values, all arbitrary
   // ------------------------------------------------------------
   localparam logic [23:0] FW = 24'h3a5c71;
   localparam logic [31:0] SER = 32'hc4b29e06;
   localparam logic [23:0] HW = 24'h51e0a7;
   localparam logic [23:0] UN = 24'h7f3318;
   localparam logic [7:0]  FWI = 8'h4d;
   localparam logic [7:0]  HWI = 8'h22;
   localparam logic [7:0]  UNI = 8'h0b;
   localparam logic [7:0]  DAY = 8'h17;
   localparam logic [7:0]  MON = 8'h09;
   localparam logic [7:0]  YR  = 8'h18;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic        clock, rstn, fault, burnerOn, startPulse, secondGasValveOpen;
   bsir_byte_t  stateNumber, errorCode, flameQuality, extraErrorInfo;
   bsir_addr_t  awaddr, araddr;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, irq;
   logic [31:0] wdata, rdata, seed;
   logic [3:0]  wstrb;
   bsir_resp_t  bresp, rresp;
   logic [34:0] expQ[$];
   int          errTotal, samplesChecked;
   initial clock = 1'b0;
   always #5 clock = ~clock;
   bsir_status_bank #(.SECOND_CYCLES(10), .FW_ARTICLE(FW), .FW_INDEX(FWI), .PROD_DAY(DAY),
      .PROD_MONTH(MON), .PROD_YEAR(YR), .SERIAL(SER), .HW_ARTICLE(HW), .HW_INDEX(HWI),
      .UNIT_ARTICLE(UN), .UNIT_INDEX(UNI)) i_dut (.clock, .rstn, .fault, .stateNumber,
      .errorCode, .flameQuality, .extraErrorInfo, .burnerOn, .startPulse, .secondGasValveOpen,
      .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
      .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq);
   bsir_bus_master i_master (.clock, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bvalid, .bready, .araddr, .arvalid, .arready, .rvalid, .rready);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] xorshift(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xorshift
   task automatic check(input string what, input logic [34:0] e, input logic [34:0] s);
      samplesChecked++;
      if (s !== e) begin
         errTotal++;
         $display("unexpected %s expected %h seen %h", what, e, s);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask : tick
   // read of one register index; upper half of rdata must stay zero
   task automatic rx(input logic [5:0] idx, input bsir_word_t v, input bsir_resp_t r = 2'h0);
      expQ.push_back({1'b0, r, 16'h0, v});
      i_master.rd({idx, 2'b00});
   endtask : rx
   task automatic wx(input logic [5:0] idx, input logic [31:0] d, input bsir_resp_t r = 2'h0);
      expQ.push_back({1'b1, r, 32'h0});
      i_master.wr({idx, 2'b00}, d);
   endtask : wx
   task automatic summarize;
      if (errTotal == 0 && samplesChecked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : summarize
   // monitor: each completed answer is matched with the oldest note
   always @(posedge clock) begin
      if (rvalid === 1'b1 && rready) check("read", expQ.pop_front(), {1'b0, rresp, rdata});
      if (bvalid === 1'b1 && bready) check("write", expQ.pop_front(), {1'b1, bresp, 32'h0});
   end
   // watchdog, far beyond the few hundred clocks the sequence needs
   initial begin
      #200000;
      errTotal++;
      summarize();
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      {rstn, fault, burnerOn, startPulse, secondGasValveOpen} = 5'h00;
      {stateNumber, errorCode, flameQuality, extraErrorInfo} = 32'h0;
      seed = 32'h9e8a;
      errTotal = 0;
      samplesChecked = 0;
      tick(5);
      rstn <= 1'b1;
      tick(2);
      rx(`BSIR_IDX_FW_LO, FW[15:0]);
      rx(`BSIR_IDX_FW_HI, {FWI, FW[23:16]});
      rx(`BSIR_IDX_DATE_LO, {MON, DAY});
      rx(`BSIR_IDX_DATE_HI, {8'h00, YR});
      rx(`BSIR_IDX_SER_LO, SER[15:0]);
      rx(`BSIR_IDX_SER_HI, SER[31:16]);
      rx(`BSIR_IDX_HW_LO, HW[15:0]);
      rx(`BSIR_IDX_HW_HI, {HWI, HW[23:16]});
      rx(`BSIR_IDX_UNIT_LO, UN[15:0]);
      rx(`BSIR_IDX_UNIT_HI, {UNI, UN[23:16]});
      // status word with random inputs, alternating normal and faulted
      for (int i = 0; i < 4; i++) begin
         seed = xorshift(seed);
         {stateNumber, errorCode, flameQuality, extraErrorInfo} <= seed;
         fault <= i[0];
         tick(2);
         rx(`BSIR_IDX_STATE, i[0] ? {seed[7:0], seed[23:16]} : {seed[15:8], seed[31:24]});
         rx(`BSIR_IDX_ERRINFO, {8'h00, seed[7:0]});
      end
      // 30 clocks on hold exactly three divider ticks, whatever the divider phase
      fault <= 1'b0;
      burnerOn <= 1'b1;
      secondGasValveOpen <= 1'b1;
      tick(30);
      burnerOn <= 1'b0;
      secondGasValveOpen <= 1'b0;
      for (int n = 0; n < 4; n++) begin
         tick(2);
         startPulse <= 1'b1;
         secondGasValveOpen <= (n < 2);
         tick(1);
         startPulse <= 1'b0;
         secondGasValveOpen <= 1'b0;
      end
      tick(2);
      rx(`BSIR_IDX_RUN_LO, 16'h0003);
      rx(`BSIR_IDX_RUN_HI, 16'h0000);
      rx(`BSIR_IDX_START_LO, 16'h0004);
      rx(`BSIR_IDX_START_HI, 16'h0000);
      rx(`BSIR_IDX_VCYC_LO, 16'h0003);
      rx(`BSIR_IDX_VCYC_HI, 16'h0000);
      rx(`BSIR_IDX_VRUN_LO, 16'h0003);
      rx(`BSIR_IDX_VRUN_HI, 16'h0000);
      // read-only place ignores writes; clears hit one counter each
      wx(`BSIR_IDX_START_LO, 32'hffff_ffff);
      rx(`BSIR_IDX_START_LO, 16'h0004);
      wx(`BSIR_IDX_CONTROL, 32'h2);
      rx(`BSIR_IDX_START_LO, 16'h0000);
      rx(`BSIR_IDX_RUN_LO, 16'h0003);
      wx(`BSIR_IDX_CONTROL, 32'h1);
      rx(`BSIR_IDX_RUN_LO, 16'h0000);
      wx(6'h3f, 32'h0, 2'h2);
      rx(6'h3f, 16'h0000, 2'h2);
      // interrupt: raised while masked, then enabled, then cleared
      wx(`BSIR_IDX_IRQ_STAT, 32'h7);
      tick(2);
      check("irq", 35'h0, {34'h0, irq});
      fault <= 1'b1;
      tick(3);
      check("irq", 35'h0, {34'h0, irq});
      rx(`BSIR_IDX_IRQ_STAT, 16'h0001);
      wx(`BSIR_IDX_IRQ_MASK, 32'h1);
      rx(`BSIR_IDX_IRQ_MASK, 16'h0001);
      tick(2);
      check("irq", 35'h1, {34'h0, irq});
      wx(`BSIR_IDX_IRQ_STAT, 32'h1);
      tick(2);
      check("irq", 35'h0, {34'h0, irq});
      // only the start event enabled; one start pulse must raise the line
      wx(`BSIR_IDX_IRQ_MASK, 32'h4);
      startPulse <= 1'b1;
      tick(1);
      startPulse <= 1'b0;
      tick(2);
      check("irq", 35'h1, {34'h0, irq});
      rx(`BSIR_IDX_IRQ_STAT, 16'h0004);
      tick(5);
      summarize();
   end
endmodule : burner_status_ident_registers_bench
